//--- csp_pkg.sv
// Shared constants and types for the standard PWM block
package csp_pkg;

  localparam int CSP_DUTY_W = 10;
  localparam int CSP_TMR_W = 8;
  localparam int CSP_REG_W = 16;
  localparam int CSP_BYTE_W = 8;
  localparam int CSP_LOW_W = 2;
  localparam int CSP_PRE_W = 6;
  localparam int CSP_POST_W = 4;
  localparam int CSP_MODE_W = 4;

  // Core clock rate and the instruction clock divide
  localparam int CSP_CORE_CLK_HZ = 40000000;
  localparam int CSP_INSTR_DIV = 4;

  // Prescale select codes: 1:1, 1:4, 1:16, 1:64
  localparam logic [1:0] CSP_PS_1 = 2'h0;
  localparam logic [1:0] CSP_PS_4 = 2'h1;
  localparam logic [1:0] CSP_PS_16 = 2'h2;
  localparam logic [1:0] CSP_PS_64 = 2'h3;

  // Mode field: top two bits both set selects PWM
  localparam int CSP_MODE_PWM_MSB = 3;
  localparam int CSP_MODE_PWM_LSB = 2;
  localparam logic [1:0] CSP_MODE_PWM = 2'h3;

  // Duty field positions in the 16-bit duty register
  localparam int CSP_LEFT_MSB = 15;
  localparam int CSP_LEFT_LSB = 6;
  localparam int CSP_RIGHT_MSB = 9;
  localparam int CSP_RIGHT_LSB = 0;

  // Reset values, plus the last value of the two low time-base bits
  localparam logic [CSP_TMR_W-1:0] CSP_PERIOD_RST = 8'hFF;
  localparam logic [CSP_TMR_W-1:0] CSP_TMR_RST = 8'h00;
  localparam logic [CSP_REG_W-1:0] CSP_DUTY_RST = 16'h0000;
  localparam logic [CSP_DUTY_W-1:0] CSP_BUF_RST = 10'h000;
  localparam logic [CSP_LOW_W-1:0] CSP_LOW_LAST = 2'h3;
  localparam logic [CSP_LOW_W-1:0] CSP_LOW_RST = 2'h0;
  localparam logic [CSP_PRE_W-1:0] CSP_PRE_RST = 6'h00;
  localparam logic [CSP_POST_W-1:0] CSP_POST_RST = 4'h0;

  typedef enum logic [1:0] {
    CSP_IDLE,
    CSP_ARMED,
    CSP_RUN
  } csp_state_e;

endpackage

//--- csp_pwm_if.sv
// Carrier between the PWM core, its time base and its duty buffer
interface csp_pwm_if;
  import csp_pkg::*;

  logic tb_step;
  logic [CSP_LOW_W-1:0] tb_low;
  logic period_load;
  logic [CSP_REG_W-1:0] duty_word;
  logic align_left;
  logic [CSP_DUTY_W-1:0] duty_next;
  logic [CSP_DUTY_W-1:0] duty_buf;

  modport tb (output tb_step, output tb_low);
  modport duty (input period_load, input duty_word, input align_left,
                output duty_next, output duty_buf);
  modport core (input tb_step, input tb_low, input duty_next, input duty_buf,
                output period_load, output duty_word, output align_left);
endinterface

//--- csp_timebase.sv
// Instruction clock phase, timer prescaler and the two low time-base bits
module csp_timebase
  import csp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sleep,
  input wire logic run,
  input wire logic [1:0] prescale_sel,
  csp_pwm_if.tb bus
);

  logic [CSP_LOW_W-1:0] phase_reg;
  logic [CSP_PRE_W-1:0] pre_reg;
  logic instr_tick;

  // Low time-base bits sit at the top two prescaler stages that the selected ratio uses
  function automatic logic [CSP_LOW_W-1:0] low_bits(input logic [1:0] sel,
                                                    input logic [CSP_PRE_W-1:0] cnt);
    logic [CSP_LOW_W-1:0] r;
    r = cnt[1:0];
    if (sel == CSP_PS_16) begin
      r = cnt[3:2];
    end else if (sel == CSP_PS_64) begin
      r = cnt[5:4];
    end
    return r;
  endfunction

  // The low field advances once every bit below it is all ones
  function automatic logic below_full(input logic [1:0] sel,
                                      input logic [CSP_PRE_W-1:0] cnt);
    logic r;
    r = 1'b1;
    if (sel == CSP_PS_16) begin
      r = &cnt[1:0];
    end else if (sel == CSP_PS_64) begin
      r = &cnt[3:0];
    end
    return r;
  endfunction

  // Oscillator stops in sleep, so the phase freezes with it
  always_ff @(posedge clk or negedge rst_b) begin // R17
    if (!rst_b) begin
      phase_reg <= CSP_LOW_RST;
    end else if (!sleep) begin // R16
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign instr_tick = !sleep && (phase_reg == CSP_LOW_LAST); // R3

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_reg <= CSP_PRE_RST;
    end else if (!run) begin
      pre_reg <= pre_reg;
    end else if (instr_tick) begin
      pre_reg <= pre_reg + 6'h01;
    end
  end

  // 1:1 uses the clock phase, other ratios the prescaler stages
  always_comb begin // R9
    if (prescale_sel == CSP_PS_1) begin
      bus.tb_low = phase_reg;
      bus.tb_step = run && !sleep;
    end else begin
      bus.tb_low = low_bits(prescale_sel, pre_reg);
      bus.tb_step = run && instr_tick && below_full(prescale_sel, pre_reg);
    end
  end

endmodule

//--- csp_duty.sv
// Duty alignment decode and the period-latched duty buffer
module csp_duty
  import csp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  csp_pwm_if.duty bus
);

  logic [CSP_DUTY_W-1:0] buf_reg;

  // Left alignment keeps the top ten bits, right the bottom ten
  function automatic logic [CSP_DUTY_W-1:0] align_duty(input logic left,
                                                       input logic [CSP_REG_W-1:0] w);
    logic [CSP_DUTY_W-1:0] r;
    r = w[CSP_RIGHT_MSB:CSP_RIGHT_LSB];
    if (left) begin
      r = w[CSP_LEFT_MSB:CSP_LEFT_LSB];
    end
    return r;
  endfunction

  assign bus.duty_next = align_duty(bus.align_left, bus.duty_word); // R6 R7

  // Register writes land anywhere; only a period end moves them here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_reg <= CSP_BUF_RST;
    end else if (bus.period_load) begin // R4 R5
      buf_reg <= bus.duty_next;
    end
  end

  assign bus.duty_buf = buf_reg;

endmodule

//--- csp_pwm_top.sv
// Standard 10-bit PWM unit with its 8-bit period timer
// Functional notes
// R1: Compare unusable in sleep; interrupt wakes device
// R2: PWM waveform on pin, ten-bit resolution
// R3: Software clocks period timer from Fosc/4
// R4: Period match clears count, sets pin, latches; code sets the pin only when the latched duty is nonzero
// R5: Duty writes anytime, applied at period match
// R6: Alignment select places duty low or high
// R7: Left uses bits 15..6, right 9..0
// R8: Eight-bit timer counts the PWM period
// R9: Time base adds phase or prescaler bits
// R10: Pin clears when time base reaches duty
// R11: Period is (limit+1) times 4 times prescale
// R12: Postscaler only paces flag, not period
// R13: Pulse width is duty times Tosc times prescale
// R14: Resolution log2 of 4(limit+1), max ten
// R15: Duty beyond period leaves pin unchanged
// R16: Sleep freezes timer, state and pin level
// R17: Output frequency tracks core clock
// R18: Reset restores registers, pins to input
// R19: Software order: pin off, setup, wait, enable
module csp_pwm_top
  import csp_pkg::*;
#(
  parameter int DUTY_W = CSP_DUTY_W,
  parameter int TMR_W = CSP_TMR_W
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic SLEEP,
  input wire logic MODULE_EN,
  input wire logic [CSP_MODE_W-1:0] MODE,
  input wire logic DUTY_ALIGN_SEL,
  input wire logic DUTY_WR_LO,
  input wire logic DUTY_WR_HI,
  input wire logic [CSP_BYTE_W-1:0] DUTY_WR_DATA,
  input wire logic PERIOD_WR,
  input wire logic [CSP_TMR_W-1:0] PERIOD_WR_DATA,
  input wire logic TIMER_RUN_ENABLE,
  input wire logic [1:0] TIMER_PRESCALE_SEL,
  input wire logic [CSP_POST_W-1:0] TIMER_POSTSCALE_SEL,
  input wire logic TIMER_FLAG_CLR,
  input wire logic TIMER_IRQ_EN,
  input wire logic PIN_DIRECTION_BIT,
  input wire logic OPEN_DRAIN_EN,
  output logic MODULE_OUTPUT_PIN,
  output logic MODULE_OUTPUT_PIN_OE,
  output logic OUTPUT_STATE,
  output logic [CSP_TMR_W-1:0] PERIOD_COUNTER,
  output logic [CSP_TMR_W-1:0] PERIOD_LIMIT_REG,
  output logic [CSP_REG_W-1:0] DUTY_VALUE_REG,
  output logic TIMER_MATCH_FLAG,
  output logic WAKE_REQ
);

  // The time base is the timer with two low bits appended
  if (DUTY_W != TMR_W + CSP_LOW_W) begin : g_width_check
    $error("Duty width must equal timer width plus two");
  end
  if (DUTY_W != CSP_DUTY_W || TMR_W != CSP_TMR_W) begin : g_fixed_check
    $error("Only the ten-bit duty and eight-bit timer are supported");
  end

  if ((1 << CSP_LOW_W) != CSP_INSTR_DIV) begin : g_div_check
    $error("Two low time-base bits must span the instruction clock divide");
  end

  if (CSP_MODE_PWM_MSB >= CSP_MODE_W || CSP_MODE_PWM_LSB > CSP_MODE_PWM_MSB) begin : g_mode_check
    $error("PWM mode field must lie inside the mode input");
  end

  csp_pwm_if pwm_bus ();

  logic [CSP_TMR_W-1:0] tmr_reg;
  logic [CSP_TMR_W-1:0] period_reg;
  logic [CSP_BYTE_W-1:0] duty_lo_reg;
  logic [CSP_BYTE_W-1:0] duty_hi_reg;
  logic [CSP_POST_W-1:0] post_reg;
  logic flag_reg;
  logic wake_reg;
  logic out_reg;
  logic pin_reg;
  logic oe_reg;
  csp_state_e state_reg;
  csp_state_e state_next;

  logic pwm_mode;
  logic pwm_active;
  logic tmr_tick;
  logic period_end;
  logic [CSP_DUTY_W-1:0] tb_now;
  logic [CSP_DUTY_W-1:0] tb_plus1;
  logic duty_hit;
  logic post_done;
  logic latch_set;
  logic latch_clr;
  logic [CSP_REG_W-1:0] duty_word;

  // Mode decode; only the top two mode bits matter for PWM
  function automatic logic mode_is_pwm(input logic [CSP_MODE_W-1:0] m);
    return m[CSP_MODE_PWM_MSB:CSP_MODE_PWM_LSB] == CSP_MODE_PWM;
  endfunction

  // Zero duty keeps the latch low for the whole period
  function automatic logic duty_nonzero(input logic [CSP_DUTY_W-1:0] d);
    return d != CSP_BUF_RST;
  endfunction

  assign pwm_mode = mode_is_pwm(MODE);
  assign pwm_active = MODULE_EN && pwm_mode;

  csp_timebase u_timebase (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .sleep(SLEEP),
    .run(TIMER_RUN_ENABLE),
    .prescale_sel(TIMER_PRESCALE_SEL),
    .bus(pwm_bus.tb)
  );

  csp_duty u_duty (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .bus(pwm_bus.duty)
  );

  assign pwm_bus.duty_word = duty_word;
  assign pwm_bus.align_left = DUTY_ALIGN_SEL; // R6

  // Timer steps when the low bits roll over from their last value
  assign tmr_tick = pwm_bus.tb_step && (pwm_bus.tb_low == CSP_LOW_LAST); // R8
  // Step after count equals limit ends the period: (limit+1)*4*prescale
  assign period_end = tmr_tick && (tmr_reg == period_reg); // R4 R11
  assign pwm_bus.period_load = period_end;

  assign tb_now = {tmr_reg, pwm_bus.tb_low}; // R9
  assign tb_plus1 = tb_now + 10'h001;
  // Looking one step ahead keeps the high time at exactly duty steps
  assign duty_hit = pwm_bus.tb_step && (tb_plus1 == pwm_bus.duty_buf); // R10 R13

  // Period timer; sleep stops its steps so the count simply holds
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R16
    if (!RST_B) begin
      tmr_reg <= CSP_TMR_RST;
    end else if (period_end) begin // R4
      tmr_reg <= CSP_TMR_RST;
    end else if (tmr_tick) begin
      tmr_reg <= tmr_reg + 8'h01;
    end
  end

  // Period limit; a small limit trades resolution for frequency
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R14
    if (!RST_B) begin
      period_reg <= CSP_PERIOD_RST; // R18
    end else if (PERIOD_WR) begin
      period_reg <= PERIOD_WR_DATA;
    end
  end

  // Duty register bytes may be written at any time
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R5
    if (!RST_B) begin
      duty_lo_reg <= CSP_DUTY_RST[CSP_BYTE_W-1:0]; // R18
    end else if (DUTY_WR_LO) begin
      duty_lo_reg <= DUTY_WR_DATA;
    end
  end

  // Each byte has its own flops, so either may be written alone
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R5 R7
    if (!RST_B) begin
      duty_hi_reg <= CSP_DUTY_RST[CSP_REG_W-1:CSP_BYTE_W]; // R18
    end else if (DUTY_WR_HI) begin
      duty_hi_reg <= DUTY_WR_DATA;
    end
  end

  assign duty_word = {duty_hi_reg, duty_lo_reg};

  // Postscaler counts period ends for the flag only
  assign post_done = period_end && (post_reg == TIMER_POSTSCALE_SEL); // R12

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      post_reg <= CSP_POST_RST;
    end else if (post_done) begin
      post_reg <= CSP_POST_RST;
    end else if (period_end) begin
      post_reg <= post_reg + 4'h1;
    end
  end

  // Sticky flag; a new set beats a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R19
    if (!RST_B) begin
      flag_reg <= 1'b0;
    end else if (post_done) begin
      flag_reg <= 1'b1;
    end else if (TIMER_FLAG_CLR) begin
      flag_reg <= 1'b0;
    end
  end

  // Only an enabled flag can wake a sleeping core
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R1
    if (!RST_B) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= SLEEP && TIMER_IRQ_EN && (flag_reg || post_done);
    end
  end

  // Armed waits for a period end so the first pulse is whole
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSP_IDLE: begin
        if (pwm_active) begin
          state_next = CSP_ARMED;
        end
      end
      CSP_ARMED: begin
        if (!pwm_active) begin
          state_next = CSP_IDLE;
        end else if (period_end) begin
          state_next = CSP_RUN;
        end
      end
      CSP_RUN: begin
        if (!pwm_active) begin
          state_next = CSP_IDLE;
        end
      end
      default: begin
        state_next = CSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= CSP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // A duty beyond the period never matches, so the latch stays put
  // Set and clear decode; a period end outranks a duty match
  always_comb begin
    latch_set = 1'b0;
    latch_clr = 1'b0;
    if (period_end) begin // R4
      latch_set = duty_nonzero(pwm_bus.duty_next);
      latch_clr = !duty_nonzero(pwm_bus.duty_next);
    end else if (state_reg == CSP_RUN && duty_hit) begin // R10 R15
      latch_clr = 1'b1;
    end
  end

  // Output latch; leaving PWM mode drops it to the default low level
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R2
    if (!RST_B) begin
      out_reg <= 1'b0;
    end else if (!pwm_active) begin
      out_reg <= 1'b0;
    end else if (latch_set) begin // R4
      out_reg <= 1'b1;
    end else if (latch_clr) begin // R10
      out_reg <= 1'b0;
    end
  end

  // Pin level; open drain only ever drives the low level
  always_ff @(posedge CORE_CLK or negedge RST_B) begin // R2
    if (!RST_B) begin
      pin_reg <= 1'b0;
    end else if (OPEN_DRAIN_EN) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= out_reg;
    end
  end

  // Output enable; the direction bit wins, so setup can hold the pin off
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      oe_reg <= 1'b0; // R18
    end else if (PIN_DIRECTION_BIT || !pwm_active) begin
      oe_reg <= 1'b0;
    end else if (OPEN_DRAIN_EN) begin
      oe_reg <= !out_reg;
    end else begin
      oe_reg <= 1'b1;
    end
  end

  assign MODULE_OUTPUT_PIN = pin_reg;
  assign MODULE_OUTPUT_PIN_OE = oe_reg;
  assign OUTPUT_STATE = out_reg;
  assign PERIOD_COUNTER = tmr_reg;
  assign PERIOD_LIMIT_REG = period_reg;
  assign DUTY_VALUE_REG = duty_word;
  assign TIMER_MATCH_FLAG = flag_reg;
  assign WAKE_REQ = wake_reg;

endmodule

//--- csp_pwm_props.sv
// Port-level checks for the standard PWM unit
module csp_pwm_props
  import csp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic SLEEP,
  input wire logic MODULE_EN,
  input wire logic [CSP_MODE_W-1:0] MODE,
  input wire logic DUTY_WR_LO,
  input wire logic DUTY_WR_HI,
  input wire logic [CSP_BYTE_W-1:0] DUTY_WR_DATA,
  input wire logic PERIOD_WR,
  input wire logic [CSP_TMR_W-1:0] PERIOD_WR_DATA,
  input wire logic TIMER_RUN_ENABLE,
  input wire logic [1:0] TIMER_PRESCALE_SEL,
  input wire logic PIN_DIRECTION_BIT,
  input wire logic OPEN_DRAIN_EN,
  input wire logic MODULE_OUTPUT_PIN,
  input wire logic MODULE_OUTPUT_PIN_OE,
  input wire logic OUTPUT_STATE,
  input wire logic [CSP_TMR_W-1:0] PERIOD_COUNTER,
  input wire logic [CSP_TMR_W-1:0] PERIOD_LIMIT_REG,
  input wire logic [CSP_REG_W-1:0] DUTY_VALUE_REG
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Gap is judged only while setup is still, since writes may stretch one period
  logic [16:0] gap_reg;
  logic seen_reg;
  logic quiet;
  assign quiet = MODULE_EN && TIMER_RUN_ENABLE && !SLEEP && !PERIOD_WR && !DUTY_WR_LO
    && !DUTY_WR_HI;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_reg <= 17'h00000;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= $rose(OUTPUT_STATE) ? 17'h00001 : gap_reg + 17'h00001;
      seen_reg <= quiet && (seen_reg || $rose(OUTPUT_STATE));
    end
  end
  property p_gap;
    $rose(OUTPUT_STATE) && seen_reg && quiet |->
      gap_reg == ((({9'h000, PERIOD_LIMIT_REG} + 17'h00001) << 2) << {TIMER_PRESCALE_SEL, 1'b0});
  endproperty
  a_gap: assert property (p_gap) else $error("period length wrong");
  property p_sleep_hold;
    SLEEP && $past(SLEEP) |-> $stable(PERIOD_COUNTER) && $stable(OUTPUT_STATE);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("state moved in sleep");
  property p_duty_lo;
    DUTY_WR_LO |=> DUTY_VALUE_REG[7:0] == $past(DUTY_WR_DATA);
  endproperty
  a_duty_lo: assert property (p_duty_lo) else $error("duty low byte not taken");
  property p_duty_hi;
    DUTY_WR_HI |=> DUTY_VALUE_REG[15:8] == $past(DUTY_WR_DATA);
  endproperty
  a_duty_hi: assert property (p_duty_hi) else $error("duty high byte not taken");
  property p_period_wr;
    PERIOD_WR |=> PERIOD_LIMIT_REG == $past(PERIOD_WR_DATA);
  endproperty
  a_period_wr: assert property (p_period_wr) else $error("period limit not taken");
  property p_wrap;
    $changed(PERIOD_COUNTER) && $past(PERIOD_COUNTER) == $past(PERIOD_LIMIT_REG)
      |-> PERIOD_COUNTER == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count not cleared at limit");
  property p_step;
    $changed(PERIOD_COUNTER) |->
      PERIOD_COUNTER == 8'h00 || PERIOD_COUNTER == $past(PERIOD_COUNTER) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_oe_dir;
    PIN_DIRECTION_BIT |=> !MODULE_OUTPUT_PIN_OE;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin driven while input");
  property p_pin_follow;
    !OPEN_DRAIN_EN && !PIN_DIRECTION_BIT && MODULE_EN && MODE[3:2] == 2'h3
      |=> MODULE_OUTPUT_PIN == $past(OUTPUT_STATE);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin lost the latch");
endmodule

bind csp_pwm_top csp_pwm_props u_props (.CORE_CLK, .RST_B, .SLEEP, .MODULE_EN, .MODE,
  .DUTY_WR_LO, .DUTY_WR_HI, .DUTY_WR_DATA, .PERIOD_WR, .PERIOD_WR_DATA, .TIMER_RUN_ENABLE,
  .TIMER_PRESCALE_SEL, .PIN_DIRECTION_BIT, .OPEN_DRAIN_EN, .MODULE_OUTPUT_PIN,
  .MODULE_OUTPUT_PIN_OE, .OUTPUT_STATE, .PERIOD_COUNTER, .PERIOD_LIMIT_REG, .DUTY_VALUE_REG);

//--- csp_load_model.sv
// External load on the PWM pin, with a pull-up, timing high and period lengths
module csp_load_model (
  input wire logic clk,
  input wire logic pin,
  input wire logic oe,
  output logic wire_lvl,
  output int high_len,
  output int period_len,
  output int rises
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev = 1'b1;
  int hc = 0;
  int pc = 0;
  // Released line is pulled high, so open drain and input mode read as high
  assign wire_lvl = oe ? pin : 1'b1;
  always @(posedge clk) begin
    prev <= wire_lvl;
    hc <= wire_lvl ? hc + 1 : 0;
    pc <= pc + 1;
    if (wire_lvl && !prev) begin
      rises <= rises + 1;
      period_len <= pc;
      pc <= 1;
    end
    if (!wire_lvl && prev) begin
      high_len <= hc;
    end
  end
endmodule

//--- csp_pwm_top_tb.sv
// Self-checking bench for the standard PWM unit
module csp_pwm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, slp = 1'b0, en = 1'b0, align = 1'b0, wlo = 1'b0;
  logic whi = 1'b0, pwr = 1'b0, run = 1'b0, fclr = 1'b0, dir = 1'b1, od = 1'b0, irq = 1'b1;
  logic [3:0] mode = 4'h0, post = 4'h0;
  logic [7:0] wdata = 8'h00, pdata = 8'h00, c;
  logic [1:0] ps = 2'h0;
  logic pin, oe, ost, flag, wake, wl;
  logic [7:0] cnt, lim;
  logic [15:0] dreg;
  int high_len, period_len, rises, r, i, k, fails = 0, samples_checked = 0;
  // Limits never fall from row to row so a stopped count never sits above the new limit
  logic [7:0] t_lim [5] = '{8'h00, 8'h01, 8'h03, 8'h03, 8'h0F};
  logic [1:0] t_ps [5] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h0};
  logic [9:0] t_duty [5] = '{10'h002, 10'h003, 10'h005, 10'h009, 10'h03F};
  logic t_left [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic t_od [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [3:0] t_post [5] = '{4'h0, 4'h3, 4'hF, 4'h0, 4'h7};

  csp_pwm_top uut (.CORE_CLK(clk), .RST_B(rst_b), .SLEEP(slp), .MODULE_EN(en), .MODE(mode),
    .DUTY_ALIGN_SEL(align), .DUTY_WR_LO(wlo), .DUTY_WR_HI(whi), .DUTY_WR_DATA(wdata),
    .PERIOD_WR(pwr), .PERIOD_WR_DATA(pdata), .TIMER_RUN_ENABLE(run),
    .TIMER_PRESCALE_SEL(ps), .TIMER_POSTSCALE_SEL(post), .TIMER_FLAG_CLR(fclr),
    .TIMER_IRQ_EN(irq), .PIN_DIRECTION_BIT(dir), .OPEN_DRAIN_EN(od),
    .MODULE_OUTPUT_PIN(pin), .MODULE_OUTPUT_PIN_OE(oe), .OUTPUT_STATE(ost),
    .PERIOD_COUNTER(cnt), .PERIOD_LIMIT_REG(lim), .DUTY_VALUE_REG(dreg),
    .TIMER_MATCH_FLAG(flag), .WAKE_REQ(wake));
  csp_load_model u_load (.clk(clk), .pin(pin), .oe(oe), .wire_lvl(wl),
    .high_len(high_len), .period_len(period_len), .rises(rises));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      fails++;
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task wr_per(input logic [7:0] p);
    pdata = p;
    pwr = 1'b1;
    tick(1);
    pwr = 1'b0;
  endtask

  // High byte first, then low byte; alignment picks where the ten bits sit
  task wr_duty(input logic [9:0] d, input logic left);
    align = left;
    wdata = left ? d[9:2] : {6'h00, d[9:8]};
    whi = 1'b1;
    tick(1);
    wdata = left ? {d[1:0], 6'h00} : d[7:0];
    whi = 1'b0;
    wlo = 1'b1;
    tick(1);
    wlo = 1'b0;
  endtask

  task wait_rises(input int n);
    int r0;
    r0 = rises;
    for (k = 0; rises < r0 + n; k++) begin
      if (k > 4000) begin
        $display("MISMATCH rises expected %0d seen %0d", r0 + n, rises);
        fails++;
        give_verdict;
      end
      tick(1);
    end
  endtask

  initial begin
    tick(8);
    rst_b = 1'b1;
    tick(1);
    chk("limit", 17'h000FF, lim);
    chk("duty_reg", 17'h0, dreg);
    chk("count", 17'h0, cnt);
    chk("oe", 17'h0, oe);
    wr_per(8'h00);
    mode = 4'hC;
    en = 1'b1;
    wr_duty(10'h002, 1'b0);
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    run = 1'b1;
    for (k = 0; k < 200 && flag !== 1'b1; k++) tick(1);
    if (flag !== 1'b1) begin
      $display("MISMATCH flag expected 1 seen %b", flag);
      fails++;
      give_verdict;
    end
    chk("oe_off", 17'h0, oe);
    dir = 1'b0;
    $display("setup done");
    for (i = 0; i < 5; i++) begin
      run = 1'b0;
      ps = t_ps[i];
      od = t_od[i];
      post = t_post[i];
      wr_per(t_lim[i]);
      wr_duty(t_duty[i], t_left[i]);
      chk("duty_reg", t_left[i] ? {t_duty[i], 6'h00} : {6'h00, t_duty[i]}, dreg);
      run = 1'b1;
      wait_rises(3);
      chk("period", ({9'h000, t_lim[i]} + 17'h1) << (2 + 2 * t_ps[i]), period_len);
      chk("width", {7'h00, t_duty[i]} << (2 * t_ps[i]), high_len);
      $display("row %0d done", i);
    end
    // Zero duty never sets the pin; duty past the period never clears it
    for (i = 0; i < 2; i++) begin
      wr_duty(i ? 10'h3FF : 10'h000, 1'b0);
      tick(128);
      r = rises;
      tick(128);
      chk("rises", r, rises);
      chk("level", i, wl);
    end
    $display("hold tests done");
    wr_duty(10'h020, 1'b0);
    tick(128);
    slp = 1'b1;
    tick(2);
    c = cnt;
    tick(40);
    chk("sleep_count", c, cnt);
    chk("wake", 17'h1, wake);
    irq = 1'b0;
    tick(2);
    chk("wake_masked", 17'h0, wake);
    irq = 1'b1;
    slp = 1'b0;
    wait_rises(2);
    $display("sleep test done");
    rst_b = 1'b0;
    tick(2);
    chk("rst_oe", 17'h0, oe);
    chk("rst_limit", 17'h000FF, lim);
    chk("rst_latch", 17'h0, ost);
    rst_b = 1'b1;
    $display("reset test done");
    give_verdict;
  end
endmodule
